// *** core/bsfs_seq.sv ***
// Start-up and fault sequencer for a synchronous buck gate-drive pair.
// Assumes raw comparator levels on cmp_raw and a classic Wishbone master.
// Operation
// RULE_01: Both drivers off while supply or enable lockout reports low.
// RULE_02: Resume operation once supply and enable are both above thresholds.
// RULE_03: Power-on-ready only when all inputs valid; it launches soft-start.
// RULE_04: Turn on only after enable comparator reports above rising threshold.
// RULE_05: Pre-biased start keeps low side off until first high-side pulse.
// RULE_06: Low-side duty steps 25, 50, 75 then 100 percent.
// RULE_07: Pulses per step fixed internally: 32, 16, 8.
// RULE_08: Soft-start ramps linearly from zero to 3 V clamp, limiting reference.
// RULE_09: Over-current detection stays active during soft-start.
// RULE_10: Enable below falling threshold puts both drivers high-impedance.
// RULE_11: Soft-start pulled below 0.3 V: high side off, low side on.
// RULE_12: Outside party releases soft-start node to restart.
// RULE_13: Over-current flagged when sense below ground while low side conducts.
// RULE_14: Over-current latches flag and forces hiccup mode.
// RULE_15: Hiccup holds soft-start low for 4096 cycles, then clears and restarts.
// RULE_16: Hiccup and soft-start repeat while the overload persists.
// RULE_17: Over-current ignored for 160 ns after low-side drive rises.
// RULE_18: Over-temperature turns both switches off and discharges soft-start.
// RULE_19: Restart automatically once over-temperature comparator clears.
// RULE_20: Release power-good once feedback comparator reports in regulation.
// RULE_21: High-side pulses at least 50 ns; 100 ns recommended.
// RULE_22: Each switching cycle keeps an off time of at most 200 ns; the code clamps on time so off time is at least 200 ns.
// RULE_23: Power-good also needs soft-start above 2.1 V.
// RULE_24: Comparators synchronised; hiccup counter clears without power-on-ready.
`timescale 1ns/1ps
module bsfs_seq #(
    parameter int SW_PERIOD = bsfs_pkg::SW_PERIOD_CYC,
    parameter int HICCUP_N  = bsfs_pkg::HICCUP_SW_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire bsfs_pkg::bsfs_cmp_t cmp_raw,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    output bsfs_pkg::bsfs_drv_t      drv,
    output logic                     power_good_out,
    output logic                     power_good_oe,
    output logic                     power_on_ready,
    output logic      [11:0]         ss_level_mv
);
    bsfs_pkg::bsfs_cmp_t   cmp;
    bsfs_pkg::bsfs_state_t state;
    bsfs_pkg::bsfs_state_t next_state;
    bsfs_pkg::bsfs_drv_t   next_drv;
    logic [7:0]  sw_cnt;
    logic [7:0]  on_req;
    logic [7:0]  ss_step;
    logic [7:0]  on_time;
    logic [7:0]  off_len;
    logic [7:0]  ls_len;
    logic [11:0] ss_level;
    logic [12:0] ss_sum;
    logic [12:0] hic_cnt;
    logic [15:0] hic_total;
    logic [1:0]  ls_step;
    logic [5:0]  ls_pulses;
    logic [2:0]  blank_cnt;
    logic        hs_seen;
    logic        ocp_flag;
    logic        por;
    logic        switching;
    logic        period_end;
    logic        ocp_hit;
    logic        hic_done;
    logic        enter_soft;
    logic        next_pg;
    logic        wb_req;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] bsfs_on_clamp(input logic [7:0] req);
        logic [7:0] max_on;
        max_on = 8'(SW_PERIOD - bsfs_pkg::OFF_MAX_CYC);
        if (req < 8'(bsfs_pkg::MIN_ON_CYC)) begin
            return 8'(bsfs_pkg::MIN_ON_CYC);
        end else if (req > max_on) begin
            return max_on;
        end
        return req;
    endfunction

    function automatic logic [5:0] bsfs_step_pulses(input logic [1:0] s);
        case (s)
            2'h0:    return 6'(bsfs_pkg::LS_STEP0_PULSES);
            2'h1:    return 6'(bsfs_pkg::LS_STEP1_PULSES);
            default: return 6'(bsfs_pkg::LS_STEP2_PULSES);
        endcase
    endfunction

    // ----------------------------------------
    // Comparator synchroniser
    // ----------------------------------------
    bsfs_sync #(
        .W ($bits(bsfs_pkg::bsfs_cmp_t))
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (cmp_raw),
        .q        (cmp)
    ); // see RULE_24

    // ----------------------------------------
    // Switching period
    // ----------------------------------------
    assign period_end = (sw_cnt == 8'(SW_PERIOD - 1));
    assign switching  = (state == bsfs_pkg::ST_SOFT) || (state == bsfs_pkg::ST_RUN);
    assign on_time    = bsfs_on_clamp(on_req); // see RULE_21, see RULE_22
    assign off_len    = 8'(SW_PERIOD) - on_time;
    assign ls_len     = (ls_step == 2'h3) ? off_len
                      : 8'(off_len[7:2] * (8'(ls_step) + 8'h01)); // see RULE_06

    always_ff @(posedge core_clk) begin
        if (!rst_n || period_end) begin
            sw_cnt <= 8'h00;
        end else begin
            sw_cnt <= sw_cnt + 8'h01;
        end
    end

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    assign por      = cmp.vcc_ok && cmp.en_ok; // see RULE_03, see RULE_04
    assign ocp_hit  = switching && drv.ls_on && cmp.ovc_below_gnd
                   && (blank_cnt >= 3'(bsfs_pkg::BLANK_CYC)); // see RULE_13, see RULE_17
    assign hic_done = period_end && (hic_cnt == 13'(HICCUP_N - 1));

    always_comb begin
        next_state = state;
        if (!por) begin
            next_state = bsfs_pkg::ST_OFF; // see RULE_01
        end else if (cmp.over_temp) begin
            next_state = bsfs_pkg::ST_THERMAL; // see RULE_18
        end else begin
            case (state)
                bsfs_pkg::ST_OFF:     next_state = bsfs_pkg::ST_SOFT; // see RULE_02
                bsfs_pkg::ST_THERMAL: next_state = bsfs_pkg::ST_SOFT; // see RULE_19
                bsfs_pkg::ST_SSDOWN: begin
                    if (!cmp.ss_pulled_low) begin
                        next_state = bsfs_pkg::ST_SOFT; // see RULE_12
                    end
                end
                bsfs_pkg::ST_HICCUP: begin
                    if (hic_done) begin
                        next_state = bsfs_pkg::ST_SOFT; // see RULE_15, see RULE_16
                    end
                end
                bsfs_pkg::ST_SOFT, bsfs_pkg::ST_RUN: begin
                    if (cmp.ss_pulled_low) begin
                        next_state = bsfs_pkg::ST_SSDOWN; // see RULE_11
                    end else if (ocp_hit) begin
                        next_state = bsfs_pkg::ST_HICCUP; // see RULE_09, see RULE_14
                    end else if (ss_level == 12'(bsfs_pkg::SS_CLAMP_MV)) begin
                        next_state = bsfs_pkg::ST_RUN;
                    end
                end
                default: next_state = bsfs_pkg::ST_OFF;
            endcase
        end
    end

    assign enter_soft = (next_state == bsfs_pkg::ST_SOFT) && (state != bsfs_pkg::ST_SOFT);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state          <= bsfs_pkg::ST_OFF;
            power_on_ready <= 1'b0;
        end else begin
            state          <= next_state;
            power_on_ready <= por; // see RULE_03
        end
    end

    // ----------------------------------------
    // Soft-start ramp
    // ----------------------------------------
    assign ss_sum = {1'b0, ss_level} + {5'h00, ss_step};

    always_ff @(posedge core_clk) begin
        if (!rst_n || enter_soft || !switching) begin
            ss_level <= 12'h000; // see RULE_15, see RULE_18
        end else if (state == bsfs_pkg::ST_SOFT && period_end) begin
            if (ss_sum >= 13'(bsfs_pkg::SS_CLAMP_MV)) begin
                ss_level <= 12'(bsfs_pkg::SS_CLAMP_MV); // see RULE_08
            end else begin
                ss_level <= ss_sum[11:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ss_level_mv <= 12'h000;
        end else begin
            ss_level_mv <= ss_level; // see RULE_08
        end
    end

    // ----------------------------------------
    // Pre-bias stepping of the low side
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n || enter_soft) begin
            hs_seen   <= 1'b0;
            ls_step   <= 2'h0;
            ls_pulses <= 6'h00;
        end else begin
            if (drv.hs_on) begin
                hs_seen <= 1'b1; // see RULE_05
            end
            if (period_end && hs_seen && ls_step != 2'h3) begin
                if (ls_pulses == bsfs_step_pulses(ls_step) - 6'h01) begin
                    ls_step   <= ls_step + 2'h1; // see RULE_07
                    ls_pulses <= 6'h00;
                end else begin
                    ls_pulses <= ls_pulses + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Gate drive
    // ----------------------------------------
    always_comb begin
        next_drv       = '0;
        next_drv.hs_oe = (state != bsfs_pkg::ST_OFF); // see RULE_10
        next_drv.ls_oe = (state != bsfs_pkg::ST_OFF);
        if (switching) begin
            next_drv.hs_on = (sw_cnt < on_time);
            next_drv.ls_on = hs_seen && (sw_cnt >= on_time)
                          && ((sw_cnt - on_time) < ls_len); // see RULE_05
        end else if (state == bsfs_pkg::ST_SSDOWN) begin
            next_drv.ls_on = 1'b1; // see RULE_11
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            drv <= '0;
        end else begin
            drv <= next_drv;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !drv.ls_on) begin
            blank_cnt <= 3'h0;
        end else if (blank_cnt < 3'(bsfs_pkg::BLANK_CYC)) begin
            blank_cnt <= blank_cnt + 3'h1; // see RULE_17
        end
    end

    // ----------------------------------------
    // Over-current hiccup
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ocp_flag <= 1'b0;
        end else begin
            ocp_flag <= ocp_hit || (ocp_flag && !hic_done); // see RULE_14, see RULE_15
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n || !por || state != bsfs_pkg::ST_HICCUP) begin
            hic_cnt <= 13'h0000; // see RULE_24
        end else if (period_end) begin
            hic_cnt <= hic_cnt + 13'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hic_total <= 16'h0000;
        end else if (ocp_hit) begin
            hic_total <= hic_total + 16'h0001; // see RULE_16
        end
    end

    // ----------------------------------------
    // Power good
    // ----------------------------------------
    assign next_pg = switching && cmp.fb_ok
                  && (ss_level >= 12'(bsfs_pkg::SS_PG_MV)); // see RULE_20, see RULE_23

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            power_good_out <= 1'b0;
            power_good_oe  <= 1'b1;
        end else begin
            power_good_out <= 1'b0;
            power_good_oe  <= !next_pg;
        end
    end

    // ----------------------------------------
    // Wishbone slave
    // ----------------------------------------
    assign wb_req = wb_cyc_i && wb_stb_i;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_ack_o && !wb_we_i) begin
                case (wb_adr_i)
                    bsfs_pkg::REG_CTRL: begin
                        wb_dat_o[bsfs_pkg::CTRL_ON_LSB +: 8]   <= on_req;
                        wb_dat_o[bsfs_pkg::CTRL_STEP_LSB +: 8] <= ss_step;
                    end
                    bsfs_pkg::REG_STATUS: begin
                        wb_dat_o[bsfs_pkg::STAT_ST_LSB +: 3]  <= state;
                        wb_dat_o[bsfs_pkg::STAT_POR_BIT]      <= power_on_ready;
                        wb_dat_o[bsfs_pkg::STAT_OCP_BIT]      <= ocp_flag;
                        wb_dat_o[bsfs_pkg::STAT_PG_BIT]       <= !power_good_oe;
                        wb_dat_o[bsfs_pkg::STAT_SS_LSB +: 12] <= ss_level;
                    end
                    bsfs_pkg::REG_HICCUP: wb_dat_o[15:0] <= hic_total;
                    default:              wb_dat_o       <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            on_req  <= bsfs_pkg::CTRL_ON_RST;
            ss_step <= bsfs_pkg::CTRL_STEP_RST;
        end else if (wb_req && wb_ack_o && wb_we_i && wb_adr_i == bsfs_pkg::REG_CTRL) begin
            if (wb_sel_i[0]) begin
                on_req <= wb_dat_i[bsfs_pkg::CTRL_ON_LSB +: 8];
            end
            if (wb_sel_i[1]) begin
                ss_step <= wb_dat_i[bsfs_pkg::CTRL_STEP_LSB +: 8];
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_lockout_off: assert property (!por |-> ##2 (!drv.hs_on && !drv.ls_on && !drv.hs_oe)) // see RULE_01
        else $error("drivers not off and released during lockout");
    a_por_soft: assert property ((state == bsfs_pkg::ST_OFF && por && !cmp.over_temp)
        |=> (state == bsfs_pkg::ST_SOFT && ss_level == 12'h000)) // see RULE_03
        else $error("power-on-ready did not start soft-start");
    a_prebias_ls: assert property ((switching && !hs_seen) |=> !drv.ls_on) // see RULE_05
        else $error("low side on before first high-side pulse");
    a_step_order: assert property (($changed(ls_step) && ls_step != 2'h0)
        |-> ls_step == $past(ls_step) + 2'h1) // see RULE_06
        else $error("low-side duty step skipped");
    a_ss_clamp: assert property (ss_level <= 12'(bsfs_pkg::SS_CLAMP_MV)) // see RULE_08
        else $error("soft-start level above clamp");
    a_ssdown_drive: assert property (state == bsfs_pkg::ST_SSDOWN
        |=> (drv.ls_on && !drv.hs_on)) // see RULE_11
        else $error("soft-start shutdown drive wrong");
    a_ocp_hiccup: assert property (ocp_hit && por && !cmp.over_temp && !cmp.ss_pulled_low
        |=> (state == bsfs_pkg::ST_HICCUP && ocp_flag)) // see RULE_14
        else $error("over-current did not enter hiccup");
    a_ocp_blank: assert property ($rose(drv.ls_on) |-> (!ocp_hit)[*4]) // see RULE_17
        else $error("over-current sampled inside blanking");
    a_thermal_off: assert property ((cmp.over_temp && por)
        |-> ##2 (!drv.hs_on && !drv.ls_on)) // see RULE_18
        else $error("switches not off on over-temperature");
    a_hiccup_len: assert property ((state == bsfs_pkg::ST_SOFT
        && $past(state) == bsfs_pkg::ST_HICCUP) |-> $past(hic_cnt) == 13'(HICCUP_N - 1)) // see RULE_15
        else $error("hiccup ended early");

    c_run: cover property (state == bsfs_pkg::ST_RUN);
    c_hiccup_back: cover property (state == bsfs_pkg::ST_HICCUP ##1 state == bsfs_pkg::ST_SOFT);
    c_ssdown: cover property (state == bsfs_pkg::ST_SSDOWN);
    c_power_good: cover property (!power_good_oe);
endmodule

// *** core/bsfs_pkg.sv ***
// Constants, field layout and carrier types of the buck start-up sequencer.
// Assumes a 25 MHz core clock driving the sequencer and its Wishbone slave.
package bsfs_pkg;

    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int MIN_ON_NS     = 50;
    localparam int MIN_ON_CYC    = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REC_ON_NS     = 100;
    localparam int REC_ON_CYC    = (REC_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_MAX_NS    = 200;
    localparam int OFF_MAX_CYC   = OFF_MAX_NS / CLK_PERIOD_NS;
    localparam int BLANK_NS      = 160;
    localparam int BLANK_CYC     = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_PERIOD_CYC = 50;
    localparam int HICCUP_SW_CYC = 4096;

    // ----------------------------------------
    // Soft-start levels in millivolts
    // ----------------------------------------
    localparam int SS_CLAMP_MV = 3000;
    localparam int SS_PG_MV    = 2100;

    // ----------------------------------------
    // Low-side start-up step pulse counts
    // ----------------------------------------
    localparam int LS_STEP0_PULSES = 32;
    localparam int LS_STEP1_PULSES = 16;
    localparam int LS_STEP2_PULSES = 8;

    // ----------------------------------------
    // Register map and fields
    // ----------------------------------------
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_STATUS    = 8'h04;
    localparam logic [7:0] REG_HICCUP    = 8'h08;
    localparam int         CTRL_ON_LSB   = 0;
    localparam int         CTRL_STEP_LSB = 8;
    localparam logic [7:0] CTRL_ON_RST   = 8'h0a;
    localparam logic [7:0] CTRL_STEP_RST = 8'h0a;
    localparam int         STAT_ST_LSB   = 0;
    localparam int         STAT_POR_BIT  = 4;
    localparam int         STAT_OCP_BIT  = 5;
    localparam int         STAT_PG_BIT   = 6;
    localparam int         STAT_SS_LSB   = 16;

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    typedef struct packed {
        logic vcc_ok;
        logic en_ok;
        logic ovc_below_gnd;
        logic over_temp;
        logic ss_pulled_low;
        logic fb_ok;
    } bsfs_cmp_t;

    typedef struct packed {
        logic hs_on;
        logic hs_oe;
        logic ls_on;
        logic ls_oe;
    } bsfs_drv_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFT,
        ST_RUN,
        ST_HICCUP,
        ST_THERMAL,
        ST_SSDOWN
    } bsfs_state_t;

endpackage

// *** core/bsfs_sync.sv ***
// Three-stage synchroniser for comparator levels.
// Assumes inputs are asynchronous to core_clk.
`timescale 1ns/1ps
module bsfs_sync #(
    parameter int W = 6
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // ----------------------------------------
    // Stages and agreement filter
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    end
endmodule

// *** verification/bsfs_plant.sv ***
// Comparator and gate-driver model facing the sequencer.
// Assumes drv from bsfs_seq and level requests from the bench.
`timescale 1ns/1ps
module bsfs_plant (
    input  wire logic                core_clk,
    input  wire logic                vcc_up,
    input  wire logic                en_up,
    input  wire logic                overload,
    input  wire logic                hot,
    input  wire logic                ss_pull,
    input  wire bsfs_pkg::bsfs_drv_t drv,
    output bsfs_pkg::bsfs_cmp_t      cmp
);
    logic fb_up = 1'b0;

    // Output charges once the high side has switched
    always @(posedge core_clk) begin
        if (!drv.hs_oe || !drv.ls_oe) fb_up <= 1'b0;
        else if (drv.hs_on) fb_up <= 1'b1;
    end

    always_comb begin
        cmp.vcc_ok        = vcc_up;
        cmp.en_ok         = en_up;
        cmp.ovc_below_gnd = overload && drv.ls_on && drv.ls_oe;
        cmp.over_temp     = hot;
        cmp.ss_pulled_low = ss_pull;
        cmp.fb_ok         = fb_up;
    end
endmodule

// *** verification/bsfs_seq_bench.sv ***
// Self-checking bench for the start-up and fault sequencer.
// Assumes bsfs_pkg, bsfs_seq and the bsfs_plant model.
`timescale 1ns/1ps
module bsfs_seq_bench;
    logic                core_clk = 1'b0;
    logic                rst_n    = 1'b0;
    logic                vcc_up   = 1'b0;
    logic                en_up    = 1'b0;
    logic                overload = 1'b0;
    logic                hot      = 1'b0;
    logic                ss_pull  = 1'b0;
    logic                cyc      = 1'b0;
    logic                stb      = 1'b0;
    logic                we       = 1'b0;
    logic [7:0]          adr      = 8'h00;
    logic [3:0]          sel      = 4'h0;
    logic [31:0]         wdat     = 32'h0;
    logic [31:0]         rdat;
    logic [31:0]         q;
    logic                ack;
    logic                pg_out;
    logic                pg_oe;
    logic                por;
    logic [11:0]         ss_mv;
    bsfs_pkg::bsfs_drv_t drv;
    bsfs_pkg::bsfs_cmp_t cmp;
    int                  miscompares = 0;
    int                  checks_done = 0;

    always #20 core_clk = ~core_clk;

    bsfs_seq #(.SW_PERIOD(50), .HICCUP_N(4)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .cmp_raw(cmp),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .drv(drv), .power_good_out(pg_out), .power_good_oe(pg_oe),
        .power_on_ready(por), .ss_level_mv(ss_mv)
    );

    bsfs_plant plant_u (
        .core_clk(core_clk), .vcc_up(vcc_up), .en_up(en_up), .overload(overload),
        .hot(hot), .ss_pull(ss_pull), .drv(drv), .cmp(cmp)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_drv(input bsfs_pkg::bsfs_drv_t exp);
        chk({28'h0, drv}, {28'h0, exp}, "drivers");
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hf;
        wdat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            test_done();
        end
    endtask

    task automatic wait_ss(input logic [11:0] mv);
        int n;
        n = 0;
        while (ss_mv !== mv && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
        chk({20'h0, ss_mv}, {20'h0, mv}, "soft-start level");
        if (ss_mv !== mv) test_done();
    endtask

    task automatic ls_width(input int exp);
        int w;
        w = 0;
        repeat (50) begin
            @(posedge core_clk);
            if (drv.ls_on) w++;
        end
        chk(w, exp, "low-side width");
    endtask

    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_drv(4'b0000);
        chk({31'h0, pg_oe}, 32'h1, "pg held low");
        chk({31'h0, pg_out}, 32'h0, "pg drive level");
        wb(1'b0, bsfs_pkg::REG_CTRL, 32'h0);
        chk(q, 32'h00000a0a, "ctrl reset");
        wb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h0, "unmapped read");
        wb(1'b1, bsfs_pkg::REG_CTRL, 32'h0000c805);
        wb(1'b0, bsfs_pkg::REG_CTRL, 32'h0);
        chk(q, 32'h0000c805, "ctrl write");
    endtask

    task automatic t_start();
        vcc_up <= 1'b1;
        settle();
        chk({31'h0, por}, 32'h0, "por without enable");
        chk_drv(4'b0000);
        en_up <= 1'b1;
        settle();
        chk({31'h0, por}, 32'h1, "por");
        wait_ss(12'd3000);
        settle();
        chk({31'h0, pg_oe}, 32'h0, "pg released");
        wb(1'b0, bsfs_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h7, 32'h2, "state run");
        ls_width(11);
        repeat (375) settle();
        ls_width(45);
    endtask

    task automatic t_ocp();
        overload <= 1'b1;
        wait_ss(12'd0);
        wb(1'b0, bsfs_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h27, 32'h23, "hiccup and flag");
        wb(1'b0, bsfs_pkg::REG_HICCUP, 32'h0);
        chk(q, 32'h1, "trip count");
        repeat (30) settle();
        wb(1'b0, bsfs_pkg::REG_HICCUP, 32'h0);
        chk(q, 32'h2, "second trip");
        overload <= 1'b0;
        wait_ss(12'd3000);
        wb(1'b0, bsfs_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h20, 32'h0, "flag cleared");
    endtask

    task automatic t_ssdown();
        ss_pull <= 1'b1;
        settle();
        chk_drv(4'b0111);
        ss_pull <= 1'b0;
        settle();
        wb(1'b0, bsfs_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h7, 32'h1, "soft after release");
    endtask

    task automatic t_thermal();
        hot <= 1'b1;
        settle();
        chk_drv(4'b0101);
        chk({20'h0, ss_mv}, 32'h0, "ss discharged");
        hot <= 1'b0;
        settle();
        wb(1'b0, bsfs_pkg::REG_STATUS, 32'h0);
        chk(q & 32'h7, 32'h1, "auto restart");
    endtask

    task automatic t_disable();
        en_up <= 1'b0;
        settle();
        chk_drv(4'b0000);
        chk({31'h0, por}, 32'h0, "por dropped");
    endtask

    initial begin
        #1ms;
        miscompares++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_start();
        t_ocp();
        t_ssdown();
        t_thermal();
        t_disable();
        test_done();
    end
endmodule
